// ===== design/tpc_pkg.sv
// Constants, register map and field layout of the paired timer with input capture
package tpc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IX_T2     = 10'h106;
    localparam logic [9:0] IX_HLD    = 10'h108;
    localparam logic [9:0] IX_T3     = 10'h10A;
    localparam logic [9:0] IX_PR2    = 10'h10C;
    localparam logic [9:0] IX_PR3    = 10'h10E;
    localparam logic [9:0] IX_CON2   = 10'h110;
    localparam logic [9:0] IX_CON3   = 10'h112;
    localparam logic [9:0] IX_C0BUF  = 10'h140;
    localparam logic [9:0] IX_C0CON  = 10'h142;
    localparam logic [9:0] IX_C1BUF  = 10'h144;
    localparam logic [9:0] IX_C1CON  = 10'h146;
    localparam logic [9:0] IX_IFLAG  = 10'h180;
    localparam logic [9:0] IX_IEN    = 10'h182;
    // Timer control fields
    localparam int B_ON   = 15;
    localparam int B_SIDL = 13;
    localparam int B_GATE = 6;
    localparam int B_PS   = 4;
    localparam int B_WIDE = 3;
    localparam int B_CS   = 1;
    localparam logic [15:0] CON2_MASK  = 16'hA07A;
    localparam logic [15:0] CON3_MASK  = 16'hA072;
    localparam logic [15:0] PER_RESET  = 16'hFFFF;
    // Capture control fields
    localparam int C_SIDL = 13;
    localparam int C_TMR  = 7;
    localparam int C_ICI  = 5;
    localparam int C_OV   = 4;
    localparam int C_BNE  = 3;
    localparam logic [15:0] CCON_MASK  = 16'h20E7;
    localparam int F_PER  = 7;
    // Capture modes
    localparam logic [2:0] M_OFF    = 3'h0;
    localparam logic [2:0] M_ANY    = 3'h1;
    localparam logic [2:0] M_FALL   = 3'h2;
    localparam logic [2:0] M_RISE   = 3'h3;
    localparam logic [2:0] M_RISE4  = 3'h4;
    localparam logic [2:0] M_RISE16 = 3'h5;
    localparam logic [2:0] M_INTR   = 3'h7;
    localparam logic [3:0] EDGE4_LAST  = 4'h3;
    localparam logic [3:0] EDGE16_LAST = 4'hF;
    localparam logic [2:0] FIFO_DEPTH  = 3'h4;
    // Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
    localparam logic [7:0] PRE_T1   = 8'h00;
    localparam logic [7:0] PRE_T8   = 8'h07;
    localparam logic [7:0] PRE_T64  = 8'h3F;
    localparam logic [7:0] PRE_T256 = 8'hFF;
endpackage

// ===== design/tpc_top.sv
// Paired 16/32-bit timer with two input capture channels behind APB
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module tpc_top (
    // Clock and reset
    input  wire  logic        MCLK,
    input  wire  logic        RESETN,
    // APB slave
    input  wire  logic        PSEL,
    input  wire  logic        PENABLE,
    input  wire  logic        PWRITE,
    input  wire  logic [11:0] PADDR,
    input  wire  logic [31:0] PWDATA,
    output logic       [31:0] PRDATA,
    output logic              PREADY,
    output logic              PSLVERR,
    // Pins and power state
    input  wire  logic        EXT_CLK,
    input  wire  logic        GATE_IN,
    input  wire  logic [1:0]  CAP_IN,
    input  wire  logic        CPU_SLEEP,
    input  wire  logic        CPU_IDLE,
    // Events
    output logic              ADC_TRIG,
    output logic              PERIOD_IRQ,
    output logic       [1:0]  CAP_IRQ,
    output logic              WAKE
);
    import tpc_pkg::*;

    typedef struct packed {
        logic [15:0]            t2;
        logic [15:0]            t3;
        logic [15:0]            hld;
        logic [15:0]            pr2;
        logic [15:0]            pr3;
        logic [15:0]            con2;
        logic [15:0]            con3;
        logic [7:0]             pre2;
        logic [7:0]             pre3;
        logic [2:0]             ext_sy;
        logic [2:0]             gate_sy;
        logic [1:0][2:0]        cap_sy;
        logic [1:0][15:0]       ccon;
        logic [1:0][3:0][15:0]  fifo;
        logic [1:0][2:0]        cnt;
        logic [1:0]             ov;
        logic [1:0][3:0]        epre;
        logic [1:0][1:0]        evc;
        logic                   pif;
        logic                   pie;
        logic [1:0]             cif;
        logic [1:0]             cie;
        logic                   adc;
        logic                   wake;
        logic [31:0]            rdata;
    } tpc_state_s;

    localparam tpc_state_s RST = '{pr2: PER_RESET, pr3: PER_RESET, default: '0};

    tpc_state_s r;
    tpc_state_s n;

    logic        wr;
    logic        rd;
    logic        setup;
    logic [9:0]  ix;
    logic [15:0] wd;
    logic        hit;
    logic        wide;
    logic        on2;
    logic        on3;
    logic        tick2;
    logic        tick3;
    logic        run2;
    logic        run3;
    logic        src2;
    logic        src3;
    logic        gate_fall;
    logic        pset;
    logic [1:0]  cset;
    logic [1:0]  cap_ev;
    logic [1:0]  cap_rise;
    logic [1:0]  cap_fall;

    function automatic logic [7:0] pre_last(input logic [1:0] sel);
        logic [7:0] v;
        v = PRE_T1;
        unique case (sel)
            2'h0: v = PRE_T1;
            2'h1: v = PRE_T8;
            2'h2: v = PRE_T64;
            2'h3: v = PRE_T256;
        endcase
        return v;
    endfunction

    always_comb begin
        logic [2:0]  md;
        logic [15:0] ts;
        logic        timer_on;
        logic        live;
        logic [2:0]  cv;
        md   = M_OFF;
        ts   = '0;
        timer_on  = 1'b0;
        live = 1'b0;
        cv   = '0;
        n     = r;
        setup = PSEL & ~PENABLE;
        wr    = PSEL & PENABLE & PWRITE;
        rd    = PSEL & PENABLE & ~PWRITE;
        ix    = PADDR[11:2];
        wd    = PWDATA[15:0];
        hit   = (PADDR[1:0] == 2'h0) &&
                (ix inside {IX_T2, IX_HLD, IX_T3, IX_PR2, IX_PR3, IX_CON2, IX_CON3,
                            IX_C0BUF, IX_C0CON, IX_C1BUF, IX_C1CON, IX_IFLAG, IX_IEN});
        pset  = 1'b0;
        cset  = '0;
        cap_ev = '0;

        // Only the second and third stages feed edge logic; the first is the metastability catcher
        n.ext_sy  = {r.ext_sy[1:0], EXT_CLK};
        n.gate_sy = {r.gate_sy[1:0], GATE_IN};
        for (int c = 0; c < 2; c++) begin
            n.cap_sy[c] = {r.cap_sy[c][1:0], CAP_IN[c]};
            cap_rise[c] = r.cap_sy[c][1] & ~r.cap_sy[c][2];
            cap_fall[c] = ~r.cap_sy[c][1] & r.cap_sy[c][2];
        end
        gate_fall = ~r.gate_sy[1] & r.gate_sy[2];

        // Timebase; in wide mode the upper control word is ignored
        wide = r.con2[B_WIDE];
        on2  = r.con2[B_ON];
        on3  = r.con3[B_ON] & ~wide;
        src2 = r.con2[B_CS] ? (r.ext_sy[1] & ~r.ext_sy[2]) :
               (r.con2[B_GATE] ? r.gate_sy[1] : 1'b1);
        src3 = r.con3[B_CS] ? (r.ext_sy[1] & ~r.ext_sy[2]) : 1'b1;
        run2 = on2 & src2 & ~CPU_SLEEP & ~(CPU_IDLE & r.con2[B_SIDL]);
        run3 = on3 & src3 & ~CPU_SLEEP & ~(CPU_IDLE & r.con3[B_SIDL]);
        tick2 = run2 && (r.pre2 == pre_last(r.con2[B_PS +: 2]));
        tick3 = run3 && (r.pre3 == pre_last(r.con3[B_PS +: 2]));
        if (run2) begin
            n.pre2 = tick2 ? 8'h00 : r.pre2 + 8'h01;
        end
        if (run3) begin
            n.pre3 = tick3 ? 8'h00 : r.pre3 + 8'h01;
        end
        n.adc = 1'b0;
        if (wide) begin
            if (tick2) begin
                if ({r.t3, r.t2} == {r.pr3, r.pr2}) begin
                    {n.t3, n.t2} = 32'h0000_0000;
                    n.adc = 1'b1;
                    pset  = 1'b1;
                end else begin
                    {n.t3, n.t2} = {r.t3, r.t2} + 32'h0000_0001;
                end
            end
            if (on2 & r.con2[B_GATE] & ~r.con2[B_CS] & gate_fall) begin
                pset = 1'b1;
            end
        end else begin
            if (tick2) begin
                n.t2 = (r.t2 == r.pr2) ? 16'h0000 : r.t2 + 16'h0001;
            end
            if (tick3) begin
                if (r.t3 == r.pr3) begin
                    n.t3  = 16'h0000;
                    n.adc = 1'b1;
                    pset  = 1'b1;
                end else begin
                    n.t3 = r.t3 + 16'h0001;
                end
            end
        end

        // Capture channels
        for (int c = 0; c < 2; c++) begin
            md   = r.ccon[c][2:0];
            ts   = r.ccon[c][C_TMR] ? r.t2 : r.t3;
            timer_on  = r.ccon[c][C_TMR] ? on2 : (wide ? on2 : r.con3[B_ON]);
            live = ~CPU_SLEEP & (~CPU_IDLE | (timer_on & ~r.ccon[c][C_SIDL]));
            if (md == M_OFF) begin
                n.epre[c] = 4'h0;
                n.evc[c]  = 2'h0;
            end else if (live) begin
                unique case (md)
                    M_ANY:  cap_ev[c] = cap_rise[c] | cap_fall[c];
                    M_FALL: cap_ev[c] = cap_fall[c];
                    M_RISE: cap_ev[c] = cap_rise[c];
                    M_RISE4, M_RISE16: begin
                        if (cap_rise[c]) begin
                            if (r.epre[c] == ((md == M_RISE4) ? EDGE4_LAST : EDGE16_LAST)) begin
                                n.epre[c] = 4'h0;
                                cap_ev[c] = 1'b1;
                            end else begin
                                n.epre[c] = r.epre[c] + 4'h1;
                            end
                        end
                    end
                    default: cap_ev[c] = 1'b0;
                endcase
            end
            // Interrupt-only mode works in every power state and stores nothing
            if (md == M_INTR && cap_rise[c]) begin
                cset[c] = 1'b1;
            end
            if (cap_ev[c]) begin
                if (md == M_ANY) begin
                    cset[c] = 1'b1;
                end else if (r.evc[c] == r.ccon[c][C_ICI +: 2]) begin
                    cset[c]  = 1'b1;
                    n.evc[c] = 2'h0;
                end else begin
                    n.evc[c] = r.evc[c] + 2'h1;
                end
            end
            // Pop on buffer read, then push into the next free slot unless the buffer was full before the read or is overflowed and not empty
            cv = r.cnt[c];
            if (rd && ix == ((c == 0) ? IX_C0BUF : IX_C1BUF) && cv != 3'h0) begin
                for (int k = 0; k < 3; k++) begin
                    n.fifo[c][k] = r.fifo[c][k + 1];
                end
                cv = cv - 3'h1;
            end
            if (cap_ev[c]) begin
                if (r.cnt[c] == FIFO_DEPTH) begin
                    if (md != M_ANY) begin
                        n.ov[c] = 1'b1;
                    end
                end else if (!(r.ov[c] && r.cnt[c] != 3'h0) && cv != FIFO_DEPTH) begin
                    n.fifo[c][cv[1:0]] = ts;
                    cv = cv + 3'h1;
                end
            end
            n.cnt[c] = cv;
        end

        // Register writes
        if (wr) begin
            unique case (ix)
                IX_T2: begin
                    n.t2 = wd;
                    if (wide) begin
                        n.t3 = r.hld;
                    end
                end
                IX_HLD:  n.hld  = wd;
                IX_T3:   n.t3   = wd;
                IX_PR2:  n.pr2  = wd;
                IX_PR3:  n.pr3  = wd;
                IX_CON2: n.con2 = wd & CON2_MASK;
                IX_CON3: n.con3 = wd & CON3_MASK;
                IX_C0CON: begin
                    n.ccon[0] = wd & CCON_MASK;
                    n.ov[0]   = r.ov[0] & wd[C_OV];
                end
                IX_C1CON: begin
                    n.ccon[1] = wd & CCON_MASK;
                    n.ov[1]   = r.ov[1] & wd[C_OV];
                end
                IX_IFLAG: begin
                    n.pif = wd[F_PER];
                    n.cif = wd[1:0];
                end
                IX_IEN: begin
                    n.pie = wd[F_PER];
                    n.cie = wd[1:0];
                end
                default: n.hld = n.hld;
            endcase
            // A prescaler whose timer has its ON bit clear is not cleared
            if (on2 && (ix == IX_T2 || ix == IX_CON2 ||
                        (wide && (ix == IX_T3 || ix == IX_CON3)))) begin
                n.pre2 = 8'h00;
            end
            if (r.con3[B_ON] && (ix == IX_T3 || ix == IX_CON3)) begin
                n.pre3 = 8'h00;
            end
        end
        // Overflow set beats a same-cycle clear
        for (int c = 0; c < 2; c++) begin
            if (cap_ev[c] && r.cnt[c] == FIFO_DEPTH && r.ccon[c][2:0] != M_ANY) begin
                n.ov[c] = 1'b1;
            end
        end
        n.pif  = n.pif | pset;
        n.cif  = n.cif | cset;
        n.wake = (|(cset & r.cie)) & (CPU_SLEEP | CPU_IDLE);

        // Read data is taken in setup so holding capture and value agree
        if (setup & ~PWRITE) begin
            n.rdata = 32'h0000_0000;
            unique case (ix)
                IX_T2: begin
                    n.rdata[15:0] = r.t2;
                    if (wide) begin
                        n.hld = r.t3;
                    end
                end
                IX_HLD:   n.rdata[15:0] = r.hld;
                IX_T3:    n.rdata[15:0] = r.t3;
                IX_PR2:   n.rdata[15:0] = r.pr2;
                IX_PR3:   n.rdata[15:0] = r.pr3;
                IX_CON2:  n.rdata[15:0] = r.con2;
                IX_CON3:  n.rdata[15:0] = r.con3;
                IX_C0BUF: n.rdata[15:0] = r.fifo[0][0];
                IX_C1BUF: n.rdata[15:0] = r.fifo[1][0];
                IX_C0CON: n.rdata[15:0] = r.ccon[0] | {11'h000, r.ov[0], r.cnt[0] != 3'h0, 3'h0};
                IX_C1CON: n.rdata[15:0] = r.ccon[1] | {11'h000, r.ov[1], r.cnt[1] != 3'h0, 3'h0};
                IX_IFLAG: n.rdata[15:0] = {8'h00, r.pif, 5'h00, r.cif};
                IX_IEN:   n.rdata[15:0] = {8'h00, r.pie, 5'h00, r.cie};
                default:  n.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            r <= RST;
        end else begin
            r <= n;
        end
    end

    assign PRDATA     = r.rdata;
    assign PREADY     = 1'b1;
    assign PSLVERR    = PSEL & PENABLE & ~hit;
    assign ADC_TRIG   = r.adc;
    assign PERIOD_IRQ = r.pif & r.pie;
    assign CAP_IRQ    = r.cif & r.cie;
    assign WAKE       = r.wake;

    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);

    sequence wide_match_s;
        wide && tick2 && ({r.t3, r.t2} == {r.pr3, r.pr2});
    endsequence
    sequence pop0_s;
        rd && ix == IX_C0BUF && r.cnt[0] != 3'h0 && !cap_ev[0];
    endsequence

    adc_on_match_a: assert property (wide_match_s |=> ADC_TRIG && r.t2 == 16'h0000)
        else $error("No trigger on wide match");
    pre_clear_a: assert property (wr && ix == IX_T2 && on2 |=> r.pre2 == 8'h00)
        else $error("Prescaler not cleared on count write");
    pre_halted_a: assert property (!r.con2[B_ON] |=> $stable(r.pre2))
        else $error("Stopped prescaler moved");
    count_kept_a: assert property (wr && ix == IX_CON2 && !tick2 |=> $stable(r.t2))
        else $error("Control write changed count");
    sleep_hold_a: assert property (CPU_SLEEP && !wr |=> $stable(r.t2) && $stable(r.t3))
        else $error("Timer counted in sleep");
    period_flag_a: assert property (wide_match_s |=> r.pif ##1 r.pif || $past(wr))
        else $error("Period flag not set");
    flag_sticky_a: assert property (r.pif && !(wr && ix == IX_IFLAG) |=> r.pif)
        else $error("Period flag dropped");
    fifo_shift_a: assert property (pop0_s |=> r.cnt[0] == $past(r.cnt[0]) - 3'h1
        && r.fifo[0][0] == $past(r.fifo[0][1]))
        else $error("Buffer read did not shift");
    overflow_set_a: assert property (cap_ev[0] && r.cnt[0] == FIFO_DEPTH && !rd
        && r.ccon[0][2:0] != M_ANY |=> r.ov[0] && r.cnt[0] == FIFO_DEPTH)
        else $error("Overflow not flagged");
    sleep_wake_a: assert property (CPU_SLEEP && r.ccon[0][2:0] == M_INTR
        && cap_rise[0] && r.cie[0] |=> WAKE ##0 CAP_IRQ[0])
        else $error("No wake from sleep");
    sleep_nostore_a: assert property (CPU_SLEEP |-> !cap_ev[0] && !cap_ev[1])
        else $error("Capture stored in sleep");

endmodule // tpc_top

// ===== verif/tpc_pins.sv
// Model of the capture pins, the gate pin and the external clock pin
`timescale 1ns/1ps
module tpc_pins (
    // Clock
    input  wire logic       clk,
    // Pins driven toward the timer
    output logic      [1:0] cap,
    output logic            gate,
    output logic            ext_clk
);
    // Every pin rests low outside the tasks, so no false edge follows reset
    initial begin
        cap = 2'b00;
        gate = 1'b0;
        ext_clk = 1'b0;
    end

    // Each level held four cycles so the synchroniser never misses it
    task automatic pulse(input int ch, input int n);
        repeat (n) begin
            @(posedge clk);
            cap[ch] <= 1'b1;
            repeat (4) @(posedge clk);
            cap[ch] <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    // External count source; each level outlasts the synchroniser
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(posedge clk);
            ext_clk <= 1'b1;
            repeat (3) @(posedge clk);
            ext_clk <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    task automatic gate_window(input int len);
        @(posedge clk);
        gate <= 1'b1;
        repeat (len) @(posedge clk);
        gate <= 1'b0;
    endtask
endmodule // tpc_pins

// ===== verif/tb.sv
// Self-checking bench for the paired timer with input capture
`timescale 1ns/1ps
module tb;
    import tpc_pkg::*;
    logic        mclk, resetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, keep;
    logic [1:0]  cap_in, cap_irq;
    logic        gate_in, ext_clk, cpu_sleep, cpu_idle, adc_trig, period_irq, wake, wake_seen;
    logic [15:0] v [5];
    logic [2:0]  md;
    int          error_cnt, n_tests, seed, adc_n;

    tpc_top u_dut (
        .MCLK(mclk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .EXT_CLK(ext_clk), .GATE_IN(gate_in), .CAP_IN(cap_in), .CPU_SLEEP(cpu_sleep),
        .CPU_IDLE(cpu_idle), .ADC_TRIG(adc_trig), .PERIOD_IRQ(period_irq), .CAP_IRQ(cap_irq),
        .WAKE(wake)
    );
    tpc_pins u_pins (.clk(mclk), .cap(cap_in), .gate(gate_in), .ext_clk(ext_clk));

    initial mclk = 1'b0;
    always #20 mclk = ~mclk;

    // ADC_TRIG and WAKE are one-cycle pulses, so they are caught at every edge
    always @(posedge mclk) begin
        if (adc_trig === 1'b1)
            adc_n <= adc_n + 1;
        if (wake === 1'b1)
            wake_seen <= 1'b1;
    end

    task automatic tally_and_finish();
        $display("Counts: %0d compares, %0d mismatches", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Start phase of a count is loose by a cycle or two; an unknown never passes
    function automatic logic near(input logic [31:0] g, input int e, input int tol);
        return (g + tol >= e) && (g <= e + tol);
    endfunction

    function automatic int ticks(input int p, input int n);
        return n / ((p == 0) ? 1 : (p == 1) ? 8 : (p == 2) ? 64 : 256);
    endfunction

    function automatic logic [15:0] cc(input logic [2:0] m);
        return 16'h0080 | {13'h0000, m};
    endfunction

    task automatic apb(input logic w, input logic [9:0] ix, input logic [15:0] d);
        int k;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= {16'h0000, d};
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [9:0] ix, input logic [15:0] d);
        apb(1'b1, ix, d);
    endtask

    task automatic rdc(input logic [9:0] ix, input logic [31:0] e);
        apb(1'b0, ix, 16'h0000);
        chk(rd, e);
    endtask

    task automatic edges(input int ch, input int n);
        u_pins.pulse(ch, n);
        repeat (4) @(posedge mclk);
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    initial begin
        seed = 54;
        {psel, penable, pwrite, cpu_sleep, cpu_idle, wake_seen} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        adc_n = 0;
        error_cnt = 0;
        n_tests = 0;
        resetn = 1'b0;
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        rdc(IX_PR2, 32'h0000_FFFF);
        rdc(IX_PR3, 32'h0000_FFFF);
        rdc(IX_CON2, 32'h0000_0000);
        rdc(IX_C1CON, 32'h0000_0000);
        apb(1'b0, 10'h3FF, 16'h0000);
        chk({rd[31:1], err}, 32'h0000_0001);
        done("reset");
        for (int p = 0; p < 4; p++) begin
            wr(IX_T3, 16'h0000);
            wr(IX_CON3, 16'h8000 | 16'(p << B_PS));
            repeat (512) @(posedge mclk);
            wr(IX_CON3, 16'(p << B_PS));
            apb(1'b0, IX_T3, 16'h0000);
            chk({31'h0, near(rd, ticks(p, 515), 2)}, 32'h0000_0001);
        end
        keep = rd;
        wr(IX_CON3, 16'h0010);
        rdc(IX_T3, keep);
        wr(IX_CON3, 16'h8020);
        // Spacing below one prescale period, total beyond several of them
        repeat (6) begin
            repeat (50) @(posedge mclk);
            wr(IX_T3, 16'h0000);
        end
        repeat (4) @(posedge mclk);
        rdc(IX_T3, 32'h0000_0000);
        wr(IX_CON3, 16'h8000);
        cpu_sleep <= 1'b1;
        apb(1'b0, IX_T3, 16'h0000);
        keep = rd;
        repeat (20) @(posedge mclk);
        rdc(IX_T3, keep);
        cpu_sleep <= 1'b0;
        wr(IX_CON3, 16'h0000);
        wr(IX_T3, 16'h0000);
        wr(IX_CON3, 16'h8002);
        u_pins.ext_pulses(5);
        repeat (4) @(posedge mclk);
        wr(IX_CON3, 16'h0000);
        rdc(IX_T3, 32'h0000_0005);
        done("prescale");
        wr(IX_T3, 16'h0000);
        wr(IX_PR3, 16'h0005);
        wr(IX_IEN, 16'h0080);
        adc_n = 0;
        wr(IX_CON3, 16'h8000);
        repeat (300) @(posedge mclk);
        wr(IX_CON3, 16'h0000);
        chk({31'h0, near(adc_n, 303 / 6, 1)}, 32'h0000_0001);
        chk({31'h0, period_irq}, 32'h0000_0001);
        repeat (20) @(posedge mclk);
        rdc(IX_IFLAG, 32'h0000_0080);
        wr(IX_IEN, 16'h0000);
        @(posedge mclk);
        chk({31'h0, period_irq}, 32'h0000_0000);
        wr(IX_IFLAG, 16'h0000);
        rdc(IX_IFLAG, 32'h0000_0000);
        done("period");
        v[0] = 16'($random(seed)) & 16'h7FFF;
        v[1] = 16'($random(seed));
        wr(IX_CON2, 16'h0008);
        wr(IX_HLD, v[0]);
        wr(IX_T2, v[1]);
        rdc(IX_T3, {16'h0000, v[0]});
        wr(IX_HLD, ~v[0]);
        rdc(IX_T2, {16'h0000, v[1]});
        rdc(IX_HLD, {16'h0000, v[0]});
        wr(IX_CON2, 16'h8048);
        rdc(IX_IFLAG, 32'h0000_0000);
        u_pins.gate_window(10);
        repeat (6) @(posedge mclk);
        rdc(IX_IFLAG, 32'h0000_0080);
        wr(IX_CON2, 16'h0000);
        wr(IX_IFLAG, 16'h0000);
        wr(IX_PR3, 16'h0000);
        wr(IX_PR2, 16'h0009);
        wr(IX_HLD, 16'h0000);
        wr(IX_CON2, 16'h0008);
        wr(IX_T2, 16'h0000);
        adc_n = 0;
        wr(IX_CON2, 16'h8008);
        repeat (97) @(posedge mclk);
        wr(IX_CON2, 16'h0008);
        chk({31'h0, near(adc_n, 100 / 10, 1)}, 32'h0000_0001);
        rdc(IX_IFLAG, 32'h0000_0080);
        wr(IX_CON2, 16'h0000);
        wr(IX_IFLAG, 16'h0000);
        done("wide");
        wr(IX_C0CON, 16'h0023);
        for (int i = 0; i < 5; i++) begin
            v[i] = 16'($random(seed));
            wr(IX_T3, v[i]);
            edges(0, 1);
            if (i < 2)
                rdc(IX_IFLAG, 32'(i));
        end
        rdc(IX_C0CON, 32'h0000_003B);
        // Exactly the stored words are read, never an empty buffer
        for (int i = 0; i < 4; i++)
            rdc(IX_C0BUF, {16'h0000, v[i]});
        rdc(IX_C0CON, 32'h0000_0033);
        wr(IX_IFLAG, 16'h0000);
        done("fifo");
        for (int m = 0; m < 3; m++) begin
            md = (m == 0) ? M_RISE : (m == 1) ? M_FALL : M_ANY;
            wr(IX_C1CON, cc(md));
            v[0] = 16'($random(seed));
            wr(IX_T2, v[0]);
            edges(1, 1);
            rdc(IX_C1BUF, {16'h0000, v[0]});
            if (md == M_ANY)
                rdc(IX_C1BUF, {16'h0000, v[0]});
            rdc(IX_C1CON, {16'h0000, cc(md)});
        end
        for (int m = 0; m < 2; m++) begin
            md = (m == 0) ? M_RISE4 : M_RISE16;
            wr(IX_C1CON, cc(md));
            edges(1, 2);
            wr(IX_C1CON, 16'h0000);
            wr(IX_C1CON, cc(md));
            v[0] = 16'($random(seed));
            wr(IX_T2, v[0]);
            edges(1, (m == 0) ? 3 : 15);
            rdc(IX_C1CON, {16'h0000, cc(md)});
            edges(1, 1);
            rdc(IX_C1BUF, {16'h0000, v[0]});
        end
        done("modes");
        wr(IX_IEN, 16'h0001);
        wr(IX_C0CON, 16'h0003);
        cpu_sleep <= 1'b1;
        edges(0, 1);
        rdc(IX_C0CON, 32'h0000_0003);
        chk({31'h0, cap_irq[0]}, 32'h0000_0000);
        wr(IX_C0CON, 16'h0007);
        wake_seen = 1'b0;
        edges(0, 1);
        chk({31'h0, wake_seen}, 32'h0000_0001);
        chk({31'h0, cap_irq[0]}, 32'h0000_0001);
        cpu_sleep <= 1'b0;
        cpu_idle <= 1'b1;
        wr(IX_C0CON, 16'h0003);
        edges(0, 1);
        rdc(IX_C0CON, 32'h0000_0003);
        wr(IX_CON3, 16'h8000);
        edges(0, 1);
        rdc(IX_C0CON, 32'h0000_000B);
        apb(1'b0, IX_C0BUF, 16'h0000);
        wr(IX_C0CON, 16'h2003);
        edges(0, 1);
        rdc(IX_C0CON, 32'h0000_2003);
        wr(IX_CON3, 16'h0000);
        cpu_idle <= 1'b0;
        done("power");
        tally_and_finish();
    end

    initial begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        tally_and_finish();
    end
endmodule // tb
